// File: include/psd_pkg.sv
// Notes on behaviour
// - The whole synthesizer, divider included, runs only while the run-enable pin is high.
// - The division mode register at RF address 21H picks the high-band or low-band input.
// - Mode bits 00 disable both inputs, 01 direct on low band, 10 swallow high, 11 swallow low.
// - The unselected input is pulled down and the selected one is biased to about half supply.
// - Direct mode divides by the programmable counter alone and pulls the high-band input down.
// - Both swallow modes divide with swallow and programmable counters and the dual prescaler.
// - With both inputs disabled by mode, the comparator, reference and charge pump keep running.
// - The divider is a two-modulus prescaler, swallow counter, programmable counter and switch.
// - The swallow and programmable counters are built from 4-bit binary down counters.
// - Software reaches the ratio register at peripheral address 41H only via the buffer.
// - Direct mode uses only the upper 12 ratio bits, all loaded into the programmable counter.
// - Swallow mode uses all 16 bits: upper 12 to the programmable, lower 4 to the swallow counter.
// - The divided output frequency is the selected input frequency divided by N.
package psd_pkg;
	localparam logic [7:0]  MODE_ADDR      = 8'h21;
	localparam logic [7:0]  RATIO_ADDR     = 8'h41;
	localparam logic [3:0]  MODE_RESET     = 4'h0;
	localparam logic [15:0] RATIO_RESET    = 16'h0000;
	localparam logic [1:0]  MODE_OFF       = 2'h0;
	localparam logic [1:0]  MODE_DIRECT_LO = 2'h1;
	localparam logic [1:0]  MODE_SWAL_HI   = 2'h2;
	localparam logic [1:0]  MODE_SWAL_LO   = 2'h3;
	localparam int          STAGE_W        = 4;
	localparam int          PROG_STAGES    = 3;
	localparam int          PROG_LSB       = 4;
	localparam int          SWAL_LSB       = 0;
	localparam logic [4:0]  PRESC_LOW_MOD  = 5'h10;
	localparam logic [4:0]  PRESC_HIGH_MOD = 5'h11;
endpackage : psd_pkg

// File: verilog/psd_down_counter.sv
`timescale 1ns/10ps
// One 4-bit binary down counter stage with parallel load
module psd_down_counter
	import psd_pkg::*;
#(
	parameter int W = STAGE_W
) (
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic         load,
	input  wire logic [W-1:0] loadVal,
	input  wire logic         dec,
	output logic      [W-1:0] count,
	output logic              isZero
);
	logic [W-1:0] count_reg;
	logic [W-1:0] count_next;

	// Load wins over decrement; wraps from zero so stages cascade as binary
	always_comb begin
		count_next = count_reg;
		if (load) begin
			count_next = loadVal;
		end else if (dec) begin
			count_next = count_reg - {{(W-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_next;
		end
	end

	assign count  = count_reg;
	assign isZero = (count_reg == '0);
endmodule : psd_down_counter

// File: verilog/psd_input_divider.sv
`timescale 1ns/10ps
// Input select block and programmable divider
module psd_input_divider
	import psd_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        clockStopRst,
	input  wire logic        runEnablePin,
	input  wire logic        highBandOscIn,
	input  wire logic        lowBandOscIn,
	input  wire logic [7:0]  rfAddr,
	input  wire logic        rfWrEn,
	input  wire logic [3:0]  rfWrData,
	output logic      [3:0]  rfRdData,
	input  wire logic [7:0]  periphAddr,
	input  wire logic        putStb,
	input  wire logic        getStb,
	input  wire logic [15:0] transferBufIn,
	output logic      [15:0] transferBufOut,
	output logic             highBandPullDown,
	output logic             lowBandPullDown,
	output logic             highBandBias,
	output logic             lowBandBias,
	output logic             refChainRun,
	output logic             dividedOut
);
	localparam int PROG_W = STAGE_W * PROG_STAGES;

	// Mode decode is used by the divider path only; pad control compares the mode bits itself
	function automatic logic isSwallow(input logic [1:0] m);
		return (m == MODE_SWAL_HI) || (m == MODE_SWAL_LO);
	endfunction : isSwallow

	// Pin synchronisers: stage one is read only by stage two
	logic [2:0] syncA_reg;
	logic [2:0] syncB_reg;
	logic [2:0] syncA_next;
	logic [2:0] syncB_next;
	logic       oscPrev_reg;
	logic       oscPrev_next;
	logic       runPrev_reg;
	logic       runPrev_next;

	logic [3:0]  mode_reg;
	logic [3:0]  mode_next;
	logic [15:0] ratio_reg;
	logic [15:0] ratio_next;
	logic [3:0]  rfRd_reg;
	logic [3:0]  rfRd_next;
	logic [15:0] bufOut_reg;
	logic [15:0] bufOut_next;

	logic [4:0]  presc_reg;
	logic [4:0]  presc_next;
	logic        divOut_reg;
	logic        divOut_next;

	logic        runSync;
	logic        oscSel;
	logic        oscEdge;
	logic        active;
	logic        swallow;
	logic        prescTick;
	logic        countTick;
	logic        terminal;
	logic        reload;
	logic [4:0]  prescMod;
	logic [PROG_W-1:0]  progCount;
	logic [STAGE_W-1:0] swalCount;
	logic               swalZero;
	logic [PROG_STAGES-1:0] progZero;
	logic [PROG_STAGES-1:0] progDec;

	assign syncA_next = {runEnablePin, highBandOscIn, lowBandOscIn};
	assign syncB_next = syncA_reg;
	assign runSync    = syncB_reg[2];

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			syncA_reg <= 3'h0;
			syncB_reg <= 3'h0;
		end else begin
			syncA_reg <= syncA_next;
			syncB_reg <= syncB_next;
		end
	end

	// Register file: mode at RF space, ratio reached via the transfer buffer
	always_comb begin
		mode_next    = mode_reg;
		ratio_next   = ratio_reg;
		bufOut_next  = bufOut_reg;
		runPrev_next = runSync;
		if (rfWrEn && rfAddr == MODE_ADDR) begin
			mode_next = {2'h0, rfWrData[1:0]};
		end
		if (clockStopRst) begin
			mode_next = {mode_reg[3:2], 2'h0};
		end
		if (putStb && periphAddr == RATIO_ADDR) begin
			ratio_next = transferBufIn;
		end
		if (getStb && periphAddr == RATIO_ADDR) begin
			bufOut_next = ratio_reg;
		end
		rfRd_next = (rfAddr == MODE_ADDR) ? mode_reg : 4'h0;
	end

	// Run-enable rising edge is a run reset; mode is kept across it
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			mode_reg    <= MODE_RESET;
			ratio_reg   <= RATIO_RESET;
			bufOut_reg  <= 16'h0000;
			rfRd_reg    <= 4'h0;
			runPrev_reg <= 1'b0;
		end else begin
			mode_reg    <= mode_next;
			ratio_reg   <= ratio_next;
			bufOut_reg  <= bufOut_next;
			rfRd_reg    <= rfRd_next;
			runPrev_reg <= runPrev_next;
		end
	end

	assign rfRdData       = rfRd_reg;
	assign transferBufOut = bufOut_reg;

	// Input select switch and pad control
	assign swallow = isSwallow(mode_reg[1:0]);
	assign active  = runSync && (mode_reg[1:0] != MODE_OFF);
	assign oscSel  = (mode_reg[1:0] == MODE_SWAL_HI) ? syncB_reg[1] : syncB_reg[0];
	assign highBandBias     = active && mode_reg[1:0] == MODE_SWAL_HI;
	assign lowBandBias      = active && mode_reg[1:0] != MODE_SWAL_HI;
	assign highBandPullDown = !highBandBias;
	assign lowBandPullDown  = !lowBandBias;
	// Comparator side keeps going with inputs off; only the pin stops it
	assign refChainRun = runSync;

	assign oscPrev_next = oscSel;
	assign oscEdge      = active && oscSel && !oscPrev_reg;

	// Dual-modulus prescaler: 17 while swallow count is nonzero, else 16
	assign prescMod  = swalZero ? PRESC_LOW_MOD : PRESC_HIGH_MOD;
	assign prescTick = oscEdge && (presc_reg == prescMod - 5'h01);
	// Direct mode bypasses the prescaler and swallow counter
	assign countTick = swallow ? prescTick : oscEdge;
	assign terminal  = countTick && (progCount == {{(PROG_W-1){1'b0}}, 1'b1});
	// Held loaded while stopped so the first period after start is whole
	assign reload    = terminal || !active || runSync != runPrev_reg;

	always_comb begin
		presc_next  = presc_reg;
		divOut_next = terminal;
		if (!active || !swallow || prescTick) begin
			presc_next = 5'h00;
		end else if (oscEdge) begin
			presc_next = presc_reg + 5'h01;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			presc_reg   <= 5'h00;
			divOut_reg  <= 1'b0;
			oscPrev_reg <= 1'b0;
		end else begin
			presc_reg   <= presc_next;
			divOut_reg  <= divOut_next;
			oscPrev_reg <= oscPrev_next;
		end
	end

	assign dividedOut = divOut_reg;

	// Swallow counter: low four ratio bits, idle in direct mode
	psd_down_counter #(.W(STAGE_W)) swalCtr (
		.clk     (clk),
		.sys_rst (sys_rst),
		.load    (reload),
		.loadVal (swallow ? ratio_reg[SWAL_LSB +: STAGE_W] : 4'h0),
		.dec     (countTick && swallow && !swalZero),
		.count   (swalCount),
		.isZero  (swalZero)
	);

	// Programmable counter: cascade of 4-bit stages from the upper 12 bits
	genvar gi;
	generate
		for (gi = 0; gi < PROG_STAGES; gi++) begin : gProg
			if (gi == 0) begin : gFirst
				assign progDec[gi] = countTick;
			end else begin : gNext
				assign progDec[gi] = progDec[gi-1] && progZero[gi-1];
			end
			psd_down_counter #(.W(STAGE_W)) progCtr (
				.clk     (clk),
				.sys_rst (sys_rst),
				.load    (reload),
				.loadVal (ratio_reg[PROG_LSB + gi*STAGE_W +: STAGE_W]),
				.dec     (progDec[gi]),
				.count   (progCount[gi*STAGE_W +: STAGE_W]),
				.isZero  (progZero[gi])
			);
		end
	endgenerate
endmodule : psd_input_divider

// File: tb/psd_osc_model.sv
`timescale 1ns/10ps
// Free-running VCO; a pulled-down pad reads low, not the last level
module psd_osc_model #(
	parameter int HALF = 30
) (
	input  wire logic pullDown,
	output logic      osc
);
	logic vco = 1'b0;
	// Period of six clocks keeps edges away from clock edges
	always #(HALF) vco = ~vco;
	assign osc = vco & ~pullDown;
endmodule : psd_osc_model

// File: tb/psd_input_divider_props.sv
`timescale 1ns/10ps
// Port-level checks of the input select and divider
module psd_input_divider_props
	import psd_pkg::*;
(
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        clockStopRst,
	input wire logic [7:0]  rfAddr,
	input wire logic        rfWrEn,
	input wire logic [3:0]  rfWrData,
	input wire logic [3:0]  rfRdData,
	input wire logic [7:0]  periphAddr,
	input wire logic        putStb,
	input wire logic        getStb,
	input wire logic [15:0] transferBufIn,
	input wire logic [15:0] transferBufOut,
	input wire logic        highBandPullDown,
	input wire logic        lowBandPullDown,
	input wire logic        highBandBias,
	input wire logic        lowBandBias,
	input wire logic        refChainRun,
	input wire logic        dividedOut
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	mode_readback_a: assert property (rfWrEn && rfAddr == MODE_ADDR && !clockStopRst ##1
		rfAddr == MODE_ADDR && !rfWrEn && !clockStopRst |=>
		rfRdData[1:0] == $past(rfWrData[1:0], 2)) else $error("mode readback");
	upper_zero_a: assert property (rfRdData[3:2] == 2'h0) else $error("upper bits");
	bias_comp_a: assert property (highBandBias != highBandPullDown &&
		lowBandBias != lowBandPullDown) else $error("bias and pulldown");
	one_input_a: assert property (!(highBandBias && lowBandBias)) else $error("two inputs");
	run_off_pads_a: assert property (!refChainRun |-> highBandPullDown && lowBandPullDown)
		else $error("pads live while off");
	run_quiet_a: assert property (!refChainRun && !$past(refChainRun) |-> !dividedOut)
		else $error("pulse while off");
	pulse_one_a: assert property (dividedOut |=> !dividedOut) else $error("long pulse");
	ratio_get_a: assert property (putStb && periphAddr == RATIO_ADDR ##1
		getStb && periphAddr == RATIO_ADDR && !putStb |=>
		transferBufOut == $past(transferBufIn, 2)) else $error("ratio readback");
endmodule : psd_input_divider_props

bind psd_input_divider psd_input_divider_props u_props (
	.clk              (clk),
	.sys_rst          (sys_rst),
	.clockStopRst     (clockStopRst),
	.rfAddr           (rfAddr),
	.rfWrEn           (rfWrEn),
	.rfWrData         (rfWrData),
	.rfRdData         (rfRdData),
	.periphAddr       (periphAddr),
	.putStb           (putStb),
	.getStb           (getStb),
	.transferBufIn    (transferBufIn),
	.transferBufOut   (transferBufOut),
	.highBandPullDown (highBandPullDown),
	.lowBandPullDown  (lowBandPullDown),
	.highBandBias     (highBandBias),
	.lowBandBias      (lowBandBias),
	.refChainRun      (refChainRun),
	.dividedOut       (dividedOut)
);

// File: tb/psd_input_divider_tb.sv
`timescale 1ns/10ps
// Directed bench: mode register, ratio transfer, division and run control
module psd_input_divider_tb
	import psd_pkg::*;
;
	logic        clk, sys_rst, clockStopRst, runEnablePin, rfWrEn, putStb, getStb;
	logic        hiOsc, loOsc, hpd, lpd, hb, lb, run, div;
	logic [7:0]  rfAddr, periphAddr;
	logic [3:0]  rfWrData, rfRdData;
	logic [15:0] bufIn, bufOut;
	int          err_count = 0;
	int          checks = 0;

	psd_input_divider uut (.clk, .sys_rst, .clockStopRst, .runEnablePin,
		.highBandOscIn(hiOsc), .lowBandOscIn(loOsc), .rfAddr, .rfWrEn, .rfWrData, .rfRdData,
		.periphAddr, .putStb, .getStb, .transferBufIn(bufIn), .transferBufOut(bufOut),
		.highBandPullDown(hpd), .lowBandPullDown(lpd), .highBandBias(hb), .lowBandBias(lb),
		.refChainRun(run), .dividedOut(div));
	psd_osc_model hiVco (.pullDown(hpd), .osc(hiOsc));
	psd_osc_model loVco (.pullDown(lpd), .osc(loOsc));

	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task step;
		@(posedge clk);
		#1;
	endtask : step

	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task stop_test;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : stop_test

	// Address stays on the mode register so the readback follows it
	task setMode(input logic [3:0] d);
		rfAddr = MODE_ADDR;
		rfWrData = d;
		rfWrEn = 1'b1;
		step;
		rfWrEn = 1'b0;
		step;
		step;
	endtask : setMode

	task putRatio(input logic [15:0] v);
		periphAddr = RATIO_ADDR;
		bufIn = v;
		putStb = 1'b1;
		step;
		putStb = 1'b0;
		getStb = 1'b1;
		step;
		getStb = 1'b0;
		step;
		chk(bufOut, v);
	endtask : putRatio

	// Leading step lets back-to-back calls find the next pulse
	task waitDiv;
		int k;
		k = 0;
		step;
		while (div !== 1'b1) begin
			step;
			k++;
			if (k > 4000) begin
				err_count++;
				stop_test;
			end
		end
	endtask : waitDiv

	// First period after a change may be stale, so it is skipped
	task gap(input int n);
		time t;
		waitDiv;
		waitDiv;
		t = $time;
		waitDiv;
		chk(16'(($time - t) / 10), 16'(n * 6));
	endtask : gap

	task tReset;
		rfAddr = MODE_ADDR;
		step;
		step;
		chk(16'(rfRdData), 16'(MODE_RESET));
		chk(16'({hpd, lpd, run}), 16'h7);
		$display("test reset done");
	endtask : tReset

	task tModes;
		for (int d = 0; d < 4; d++) begin
			setMode(4'hc | 4'(d));
			chk(16'(rfRdData), 16'(d));
			chk(16'({hpd, lpd, run}), 16'({d != 2, d == 0 || d == 2, 1'b1}));
			chk(16'({hb, lb}), 16'({d == 2, d == 1 || d == 3}));
		end
		$display("test modes done");
	endtask : tModes

	// A mode change alone does not reload; passing through off does, else a wrapped count
	// left from ratio zero would take thousands of input edges to drain
	task tDivide;
		putRatio(16'h010f);
		setMode(4'h0);
		setMode(4'h1);
		gap(16);
		setMode(4'h2);
		gap(271);
		setMode(4'h3);
		putRatio(16'h0100);
		gap(256);
		$display("test divide done");
	endtask : tDivide

	task tStop;
		clockStopRst = 1'b1;
		step;
		clockStopRst = 1'b0;
		step;
		chk(16'(rfRdData), 16'h0);
		setMode(4'h3);
		runEnablePin = 1'b0;
		repeat (40) step;
		chk(16'({hpd, lpd, run, div}), 16'hc);
		runEnablePin = 1'b1;
		repeat (4) step;
		chk(16'(rfRdData), 16'h3);
		gap(256);
		$display("test run control done");
	endtask : tStop

	initial begin
		{clockStopRst, rfWrEn, putStb, getStb} = 4'h0;
		runEnablePin = 1'b1;
		rfAddr = 8'h00;
		periphAddr = 8'h00;
		rfWrData = 4'h0;
		bufIn = 16'h0000;
		sys_rst = 1'b1;
		repeat (8) step;
		sys_rst = 1'b0;
		tReset;
		tModes;
		tDivide;
		tStop;
		stop_test;
	end
endmodule : psd_input_divider_tb
